// [src/pot_pkg.sv]
// constants, bus carrier and register map of the pwm output timer
package pot_pkg;
   localparam int CNT_W = 8;
   localparam int PRE_W = 8;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam logic [CNT_W-1:0] CNT_TOP = 8'hfe;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_PORT = 8'h80;
   localparam logic [7:0] IDX_PWRCTL = 8'h87;
   localparam logic [7:0] IDX_CMP = 8'h8e;
   localparam logic [7:0] IDX_PRE = 8'h8f;
   localparam logic [7:0] IDX_IRQEN = 8'had;
   localparam logic [7:0] IDX_STAT = 8'hc0;
   localparam logic [7:0] IDX_ENA = 8'hfe;
   // field positions
   localparam int IRQ_ALL_BIT = 7;
   localparam int IRQ_MOD_BIT = 3;
   localparam int PIN_BIT = 4;
   localparam int IDLE_BIT = 0;
   localparam int PD_BIT = 1;
   localparam int OVF_BIT = 0;
   localparam int ENA_BIT = 0;
   localparam int STAT_CNT_LSB = 8;
   // reset values and fixed read bits
   localparam logic [7:0] IRQEN_RST = 8'h00;
   localparam logic [7:0] CMP_RST = 8'hff;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [7:0] ENA_RSV = 8'hfe;
   localparam logic [7:0] PORT_RSV = 8'hef;
   localparam logic PORT_RST = 1'b1;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } pot_av_req_t;

   // low byte lane write, shared by the interrupt enable, compare and prescale registers
   function automatic logic [7:0] laneWr(input logic [7:0] old, input logic [DATA_W-1:0] wd,
                                         input logic be0);
      laneWr = be0 ? wd[7:0] : old;
   endfunction
endpackage

// [src/pot_prescaler.sv]
// divider that gives one counter step every 2*(1+prescale) clocks
`timescale 1ns/1ps
`default_nettype none
module pot_prescaler #(
   parameter int PRE_W = pot_pkg::PRE_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [PRE_W-1:0] preVal,
   output logic tick
);
   logic [PRE_W:0] divCnt_r;
   logic [PRE_W:0] termCnt;

   ////////////////////////////////////////////////////////////////////////////
   // terminal count 2*p+1; >= keeps a lowered prescale from running long
   assign termCnt = {preVal, 1'b1};
   assign tick = run && (divCnt_r >= termCnt);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         divCnt_r <= '0;
      else if (tick)
         divCnt_r <= '0;
      else if (run)
         divCnt_r <= divCnt_r + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_preRestart;
      @(posedge clk) disable iff (!rst_n)
      tick |=> divCnt_r == '0;
   endproperty
   a_preRestart: assert property (p_preRestart) else $error("divider not restarted");

   property p_preSpan;
      @(posedge clk) disable iff (!rst_n)
      tick && $stable(preVal) && $past(divCnt_r) < termCnt |-> divCnt_r == termCnt;
   endproperty
   a_preSpan: assert property (p_preSpan) else $error("step spacing wrong");
endmodule
`default_nettype wire

// [src/pwm_output_timer.sv]
// pwm output timer: modulator, avalon register slave and pin driver
`timescale 1ns/1ps
`default_nettype none
module pwm_output_timer #(
   parameter int CNT_W = pot_pkg::CNT_W,
   parameter int PRE_W = pot_pkg::PRE_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire pot_pkg::pot_av_req_t avReq,
   output logic [pot_pkg::DATA_W-1:0] avReadData,
   output logic avWaitRequest,
   input wire logic modulatorPinIn,
   output logic modulatorPinOut,
   output logic modulatorPinOe_n,
   output logic irqReq
);
   logic ackR_r;
   logic [pot_pkg::DATA_W-1:0] rdData_r;
   logic [7:0] regIdx;
   logic idxOk;
   logic wrTake;
   logic be0;
   logic [7:0] interruptEnable_r;
   logic [CNT_W-1:0] cmp_r;
   logic [PRE_W-1:0] periodPrescaleValue_r;
   logic modulatorOutputEnableReg_r;
   logic portLatch_r;
   logic idle_r;
   logic pd_r;
   logic ovf_r;
   logic [CNT_W-1:0] cnt_r;
   logic level_r;
   logic pinOut_r;
   logic pinOe_n_r;
   logic irq_r;
   logic pinSync1_r;
   logic pinSync2_r;
   logic run;
   logic tick;
   logic ovfEvt;
   logic forceHigh;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait state per access, then taken at the next edge
   assign regIdx = avReq.address[pot_pkg::ADDR_W-1:2];
   assign idxOk = (avReq.address[1:0] == 2'h0);
   assign be0 = avReq.byteenable[0];
   assign avWaitRequest = (avReq.read || avReq.write) && !ackR_r;
   assign wrTake = avReq.write && ackR_r;
   assign avReadData = rdData_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ackR_r <= 1'b0;
      else
         ackR_r <= (avReq.read || avReq.write) && !ackR_r;
   end

   // read data is latched in the wait cycle so it stands when taken
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdData_r <= '0;
      else if (avReq.read && !ackR_r)
      begin
         rdData_r <= '0;
         if (idxOk)
         begin
            unique case (regIdx)
               pot_pkg::IDX_PORT:
               begin
                  rdData_r[7:0] <= pot_pkg::PORT_RSV;
                  rdData_r[pot_pkg::PIN_BIT] <= pinSync2_r;
               end
               pot_pkg::IDX_PWRCTL:
               begin
                  rdData_r[pot_pkg::IDLE_BIT] <= idle_r;
                  rdData_r[pot_pkg::PD_BIT] <= pd_r;
               end
               pot_pkg::IDX_CMP:
                  rdData_r[CNT_W-1:0] <= cmp_r;
               pot_pkg::IDX_PRE:
                  rdData_r[PRE_W-1:0] <= periodPrescaleValue_r;
               pot_pkg::IDX_IRQEN:
                  rdData_r[7:0] <= interruptEnable_r;
               pot_pkg::IDX_STAT:
               begin
                  rdData_r[pot_pkg::OVF_BIT] <= ovf_r;
                  rdData_r[pot_pkg::STAT_CNT_LSB +: CNT_W] <= cnt_r;
               end
               pot_pkg::IDX_ENA:
               begin
                  rdData_r[7:0] <= pot_pkg::ENA_RSV;
                  rdData_r[pot_pkg::ENA_BIT] <= modulatorOutputEnableReg_r;
               end
               default:
                  rdData_r <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         interruptEnable_r <= pot_pkg::IRQEN_RST;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_IRQEN)
         interruptEnable_r <= pot_pkg::laneWr(interruptEnable_r, avReq.writedata, be0);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cmp_r <= pot_pkg::CMP_RST;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_CMP)
         cmp_r <= pot_pkg::laneWr(cmp_r, avReq.writedata, be0);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         periodPrescaleValue_r <= pot_pkg::PRE_RST;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_PRE)
         periodPrescaleValue_r <= pot_pkg::laneWr(periodPrescaleValue_r, avReq.writedata, be0);
   end

   // output stays off after reset until software sets it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         modulatorOutputEnableReg_r <= 1'b0;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_ENA && be0)
         modulatorOutputEnableReg_r <= avReq.writedata[pot_pkg::ENA_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         portLatch_r <= pot_pkg::PORT_RST;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_PORT && be0)
         portLatch_r <= avReq.writedata[pot_pkg::PIN_BIT];
   end

   // power-down is left only through reset; idle by writing zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         idle_r <= 1'b0;
         pd_r <= 1'b0;
      end
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_PWRCTL && be0)
      begin
         idle_r <= avReq.writedata[pot_pkg::IDLE_BIT];
         pd_r <= pd_r || avReq.writedata[pot_pkg::PD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // modulator; enable bit does not gate counting
   assign run = !idle_r && !pd_r;

   pot_prescaler #(
      .PRE_W(PRE_W)
   ) u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .run(run),
      .preVal(periodPrescaleValue_r),
      .tick(tick)
   );

   assign ovfEvt = tick && (cnt_r == pot_pkg::CNT_TOP);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_r <= pot_pkg::CNT_ZERO;
      else if (ovfEvt)
         cnt_r <= pot_pkg::CNT_ZERO;
      else if (tick)
         cnt_r <= cnt_r + 1'b1;
   end

   // match is checked before zero so compare 0 holds high
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         level_r <= 1'b0;
      else if (cnt_r == cmp_r)
         level_r <= 1'b1;
      else if (cnt_r == pot_pkg::CNT_ZERO)
         level_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin: strong drive when enabled, quasi-bidirectional otherwise
   assign forceHigh = idle_r || pd_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pinOut_r <= 1'b0;
         pinOe_n_r <= 1'b1;
      end
      else if (modulatorOutputEnableReg_r)
      begin
         pinOut_r <= forceHigh || level_r;
         pinOe_n_r <= 1'b0;
      end
      else
      begin
         // latch one releases to the outside weak pull-up
         pinOut_r <= 1'b0;
         pinOe_n_r <= portLatch_r;
      end
   end

   assign modulatorPinOut = pinOut_r;
   assign modulatorPinOe_n = pinOe_n_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pinSync1_r <= 1'b0;
         pinSync2_r <= 1'b0;
      end
      else
      begin
         pinSync1_r <= modulatorPinIn;
         pinSync2_r <= pinSync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overflow flag: a new overflow beats a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ovf_r <= 1'b0;
      else if (ovfEvt)
         ovf_r <= 1'b1;
      else if (wrTake && idxOk && regIdx == pot_pkg::IDX_STAT && be0 &&
               avReq.writedata[pot_pkg::OVF_BIT])
         ovf_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irq_r <= 1'b0;
      else
         irq_r <= ovf_r && interruptEnable_r[pot_pkg::IRQ_ALL_BIT] &&
                  interruptEnable_r[pot_pkg::IRQ_MOD_BIT];
   end

   assign irqReq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      tick && cnt_r == pot_pkg::CNT_TOP |=> cnt_r == pot_pkg::CNT_ZERO;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap at 254");

   property p_step;
      @(posedge clk) disable iff (!rst_n)
      tick && cnt_r != pot_pkg::CNT_TOP |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_step: assert property (p_step) else $error("counter did not advance");

   property p_setHigh;
      @(posedge clk) disable iff (!rst_n)
      cnt_r == cmp_r |=> level_r;
   endproperty
   a_setHigh: assert property (p_setHigh) else $error("no high on compare match");

   property p_setLow;
      @(posedge clk) disable iff (!rst_n)
      cnt_r == pot_pkg::CNT_ZERO && cmp_r != pot_pkg::CNT_ZERO |=> !level_r;
   endproperty
   a_setLow: assert property (p_setLow) else $error("no low at zero");

   property p_neverHigh;
      @(posedge clk) disable iff (!rst_n)
      cmp_r == 8'hff && !level_r |=> !level_r;
   endproperty
   a_neverHigh: assert property (p_neverHigh) else $error("pulse with compare 255");

   property p_drive;
      @(posedge clk) disable iff (!rst_n)
      modulatorOutputEnableReg_r && !forceHigh |=>
         !modulatorPinOe_n && modulatorPinOut == $past(level_r);
   endproperty
   a_drive: assert property (p_drive) else $error("pin not driven by modulator");

   property p_portMode;
      @(posedge clk) disable iff (!rst_n)
      !modulatorOutputEnableReg_r |=> modulatorPinOe_n == $past(portLatch_r) && !modulatorPinOut;
   endproperty
   a_portMode: assert property (p_portMode) else $error("port bit misdriven");

   property p_resetOff;
      @(posedge clk) disable iff (!rst_n)
      $past(!rst_n) |-> !modulatorOutputEnableReg_r && modulatorPinOe_n;
   endproperty
   a_resetOff: assert property (p_resetOff) else $error("output enabled after reset");

   property p_forceHigh;
      @(posedge clk) disable iff (!rst_n)
      modulatorOutputEnableReg_r && forceHigh |=> modulatorPinOut && !modulatorPinOe_n;
   endproperty
   a_forceHigh: assert property (p_forceHigh) else $error("pin not high in low power");

   property p_idleHold;
      @(posedge clk) disable iff (!rst_n)
      idle_r |=> cnt_r == $past(cnt_r);
   endproperty
   a_idleHold: assert property (p_idleHold) else $error("counter moved while idle");

   property p_irq;
      @(posedge clk) disable iff (!rst_n)
      ovfEvt && interruptEnable_r[pot_pkg::IRQ_ALL_BIT] && interruptEnable_r[pot_pkg::IRQ_MOD_BIT]
         ##1 $stable(interruptEnable_r) |=> irqReq;
   endproperty
   a_irq: assert property (p_irq) else $error("overflow raised no interrupt");

   property p_mask;
      @(posedge clk) disable iff (!rst_n)
      !$past(interruptEnable_r[pot_pkg::IRQ_ALL_BIT]) |-> !irqReq;
   endproperty
   a_mask: assert property (p_mask) else $error("interrupt despite global mask");
endmodule
`default_nettype wire

// [tb/pot_pin_load.sv]
// pin load model: weak pull-up plus an external driver the bench can switch on
`timescale 1ns/1ps
`default_nettype none
module pot_pin_load (
   input wire logic pinOut,
   input wire logic pinOe_n,
   input wire logic loadDrive,
   input wire logic loadVal,
   output logic pinLevel
);
   ////////////////////////////////////////////////////////////////////////////////
   // a fight between both drivers reads as unknown unless both drive the same level
   always_comb
   begin
      if (!pinOe_n && loadDrive)
         pinLevel = (pinOut === loadVal) ? pinOut : 1'bx;
      else if (!pinOe_n)
         pinLevel = pinOut;
      else if (loadDrive)
         pinLevel = loadVal;
      else
         pinLevel = 1'b1;
   end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the pwm output timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [9:0] aPort = {pot_pkg::IDX_PORT, 2'b00};
   localparam logic [9:0] aPwr = {pot_pkg::IDX_PWRCTL, 2'b00};
   localparam logic [9:0] aCmp = {pot_pkg::IDX_CMP, 2'b00};
   localparam logic [9:0] aPre = {pot_pkg::IDX_PRE, 2'b00};
   localparam logic [9:0] aIrqEn = {pot_pkg::IDX_IRQEN, 2'b00};
   localparam logic [9:0] aStat = {pot_pkg::IDX_STAT, 2'b00};
   localparam logic [9:0] aEna = {pot_pkg::IDX_ENA, 2'b00};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pot_pkg::pot_av_req_t avReq = '0;
   logic [31:0] avReadData;
   logic avWaitRequest;
   logic pinOut;
   logic pinOe_n;
   logic irqReq;
   logic pinLevel;
   logic loadDrive = 1'b0;
   logic loadVal = 1'b1;
   logic [31:0] expQ[$];
   logic [31:0] obsVal = '0;
   logic obsStb = 1'b0;
   logic chkRd = 1'b0;
   logic [7:0] endCmp [2] = '{8'h00, 8'hff};
   logic [7:0] irqEnSet [3] = '{8'h08, 8'h80, 8'h88};
   int error_cnt = 0;
   int n_compared = 0;

   always #12.5 clk = ~clk;

   pwm_output_timer i_pwm_output_timer (.clk(clk), .rst_n(rst_n), .avReq(avReq),
      .avReadData(avReadData), .avWaitRequest(avWaitRequest), .modulatorPinIn(pinLevel),
      .modulatorPinOut(pinOut), .modulatorPinOe_n(pinOe_n), .irqReq(irqReq));
   pot_pin_load i_pot_pin_load (.pinOut(pinOut), .pinOe_n(pinOe_n), .loadDrive(loadDrive),
      .loadVal(loadVal), .pinLevel(pinLevel));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got);
      logic [31:0] e;
      e = expQ.pop_front();
      n_compared++;
      if (got !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, e);
      end
   endtask

   // results are matched against the oldest note, in issue order
   always @(posedge clk)
   begin
      if (avReq.read && avWaitRequest === 1'b0 && chkRd)
         cmp(avReadData);
      if (obsStb)
         cmp(obsVal);
   end

   task automatic test_done;
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // leading edge keeps two back-to-back calls from touching read/write in one step
   task automatic busOp(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
      @(posedge clk);
      avReq.read <= !wr;
      avReq.write <= wr;
      avReq.address <= a;
      avReq.writedata <= d;
      avReq.byteenable <= 4'hf;
      do
         @(posedge clk);
      while (avWaitRequest !== 1'b0);
      q = avReadData;
      avReq.read <= 1'b0;
      avReq.write <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      busOp(1'b1, a, d, q);
   endtask

   task automatic rdChk(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      expQ.push_back(e);
      chkRd <= 1'b1;
      busOp(1'b0, a, '0, q);
      chkRd <= 1'b0;
   endtask

   task automatic rdCnt(output logic [7:0] c);
      logic [31:0] q;
      busOp(1'b0, aStat, '0, q);
      c = q[15:8];
   endtask

   task automatic obs(input logic [31:0] got, input logic [31:0] e);
      expQ.push_back(e);
      obsVal <= got;
      obsStb <= 1'b1;
      @(posedge clk);
      obsStb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic waitFor(input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (pinOut !== v && n < 5000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] pre;
      logic [7:0] cmpV;
      logic [7:0] irqEnV;
      int n;
      int hi;
      int per;
      int bad;
      void'($urandom(44));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdChk(aIrqEn, {24'h0, pot_pkg::IRQEN_RST});
      rdChk(aCmp, {24'h0, pot_pkg::CMP_RST});
      rdChk(aPre, {24'h0, pot_pkg::PRE_RST});
      rdChk(aEna, {24'h0, pot_pkg::ENA_RSV});
      rdChk(10'h004, 32'h0);
      obs({31'h0, pinOe_n}, 32'h1);
      irqEnV = 8'($urandom);
      wr(aIrqEn, {24'h0, irqEnV});
      rdChk(aIrqEn, {24'h0, irqEnV});
      pre = 8'($urandom % 4);
      cmpV = 8'(1 + $urandom % 254);
      wr(aPre, {24'h0, pre});
      wr(aCmp, {24'h0, cmpV});
      wr(aEna, 32'h1);
      waitFor(1'b1, n);
      waitFor(1'b0, n);
      waitFor(1'b1, n);
      waitFor(1'b0, hi);
      waitFor(1'b1, per);
      per = per + hi;
      obs(32'(hi), 32'((255 - cmpV) * 2 * (pre + 1)));
      obs(32'(per), 32'(255 * 2 * (pre + 1)));
      obs({31'h0, pinOe_n}, 32'h0);
      // both ends of the compare range, settled over a whole period first
      for (int i = 0; i < 2; i++)
      begin
         wr(aCmp, {24'h0, endCmp[i]});
         repeat (per + 10) @(posedge clk);
         bad = 0;
         repeat (per) @(posedge clk) if (pinOut !== (endCmp[i] == 8'h00)) bad++;
         obs(32'(bad), 32'h0);
      end
      // clearing right after the enable write drops the old flag; the wait covers a whole period so the next overflow falls inside it
      for (int i = 0; i < 3; i++)
      begin
         wr(aIrqEn, {24'h0, irqEnSet[i]});
         wr(aStat, 32'h1);
         // a request from a flag set before the clear still shows for two edges
         repeat (2) @(posedge clk);
         n = 0;
         while (irqReq !== 1'b1 && n < per + 10)
         begin
            @(posedge clk);
            n++;
         end
         obs({31'h0, irqReq}, {31'h0, irqEnSet[i] == 8'h88});
      end
      wr(aStat, 32'h1);
      repeat (4) @(posedge clk);
      obs({31'h0, irqReq}, 32'h0);
      wr(aEna, 32'h0);
      wr(aPort, 32'h10);
      loadDrive <= 1'b1;
      loadVal <= 1'b0;
      repeat (4) @(posedge clk);
      rdChk(aPort, {24'h0, pot_pkg::PORT_RSV});
      obs({31'h0, pinOe_n}, 32'h1);
      rdCnt(c1);
      repeat (20) @(posedge clk);
      rdCnt(c2);
      obs({31'h0, c1 != c2}, 32'h1);
      loadDrive <= 1'b0;
      wr(aPort, 32'h0);
      repeat (2) @(posedge clk);
      obs({30'h0, pinOe_n, pinOut}, 32'h0);
      wr(aEna, 32'h1);
      wr(aPwr, 32'h1);
      repeat (4) @(posedge clk);
      obs({30'h0, pinOe_n, pinOut}, 32'h1);
      rdCnt(c1);
      repeat (30) @(posedge clk);
      rdCnt(c2);
      obs({31'h0, c1 == c2}, 32'h1);
      wr(aPwr, 32'h0);
      wr(aPwr, 32'h2);
      repeat (4) @(posedge clk);
      obs({30'h0, pinOe_n, pinOut}, 32'h1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      obs({31'h0, pinOe_n}, 32'h1);
      rdChk(aEna, {24'h0, pot_pkg::ENA_RSV});
      test_done();
   end
endmodule
`default_nettype wire
